// *** include/pmc_pkg.sv ***
/*
 pmc_pkg: constants and carriers for the power mode control block.
 assumes a byte-wide special function register port on the core clock.
*/
package pmc_pkg;

   // ==========================================================
   // register offsets and widths
   // ==========================================================
   localparam int unsigned   PMC_DATA_W      = 8;
   localparam int unsigned   PMC_ADDR_W      = 8;
   localparam logic [7:0]    PMC_OFS_RELOAD  = 8'h86;
   localparam logic [7:0]    PMC_OFS_POWER   = 8'h87;

   // ==========================================================
   // power mode register fields
   // ==========================================================
   localparam int unsigned   PMC_BIT_BAUD_DOUBLE = 7;
   localparam int unsigned   PMC_BIT_FRM_SELECT  = 6;
   localparam int unsigned   PMC_BIT_UNUSED      = 5;
   localparam int unsigned   PMC_BIT_POWER_ON    = 4;
   localparam int unsigned   PMC_BIT_GFLAG1      = 3;
   localparam int unsigned   PMC_BIT_GFLAG0      = 2;
   localparam int unsigned   PMC_BIT_PDOWN       = 1;
   localparam int unsigned   PMC_BIT_IDLE        = 0;

   // ==========================================================
   // reset values and write mask
   // ==========================================================
   localparam logic [7:0]    PMC_RST_RELOAD  = 8'h00;
   localparam logic [7:0]    PMC_RST_POWER   = 8'h10;
   localparam logic [7:0]    PMC_WMASK_POWER = 8'hDF;

   // ==========================================================
   // timing: wake to clock-restart settle
   // ==========================================================
   localparam int unsigned   PMC_WAKE_SETTLE_NS  = 20;
   localparam int unsigned   PMC_CLK_PERIOD_PS   = 5000;
   localparam int unsigned   PMC_WAKE_SETTLE_CYC =
      (PMC_WAKE_SETTLE_NS * 1000 + PMC_CLK_PERIOD_PS - 1)
      / PMC_CLK_PERIOD_PS;

   // ==========================================================
   // types
   // ==========================================================
   typedef enum logic [1:0]
   {
      PMC_RUN     = 2'b00,
      PMC_IDLE    = 2'b01,
      PMC_PDOWN   = 2'b11,
      PMC_WAKE    = 2'b10
   } pmc_mode_e;

   typedef struct packed
   {
      logic                    wr;
      logic                    rd;
      logic [PMC_ADDR_W-1:0]   addr;
      logic [PMC_DATA_W-1:0]   wdata;
   } pmc_bus_s;

   typedef struct packed
   {
      logic                    cpu_clk_en;
      logic                    periph_clk_en;
      logic                    pc_hold;
      logic                    wake_isr_go;
   } pmc_clk_s;

endpackage : pmc_pkg

// *** design/pmc_sync.sv ***
/*
 pmc_sync: three-stage synchroniser for one external level.
 assumes the level is slow next to the clock; output moves only when
 stages two and three agree.
*/
`timescale 1ns/1ps
module pmc_sync
(
   // clock and reset
   input  wire logic   ref_clk_i,
   input  wire logic   rst_b_i,
   // level
   input  wire logic   async_i,
   output logic        level_o
);
   import pmc_pkg::*;

   typedef struct packed
   {
      logic   s1;
      logic   s2;
      logic   s3;
      logic   level;
   } pmc_sync_s;

   pmc_sync_s   q;
   pmc_sync_s   next_q;

   always_comb
   begin
      next_q    = q;
      next_q.s1 = async_i;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      if (q.s2 == q.s3)
      begin
         next_q.level = q.s3;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign level_o = q.level;

endmodule : pmc_sync

// *** design/pmc_regs.sv ***
/*
 pmc_regs: the two byte registers with their read port.
 assumes one strobe at a time; read data stands one cycle after the read.
 the power-on flag sits outside normal reset and is preset by por.
*/
`timescale 1ns/1ps
module pmc_regs
(
   // clock and resets
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        por_done_i,
   // bus
   input  wire pmc_pkg::pmc_bus_s           bus_i,
   output logic [pmc_pkg::PMC_DATA_W-1:0]   rdata_o,
   // hardware clear of mode bits on wake
   input  wire logic                        hw_clr_mode_i,
   // register contents and power write strobe
   output logic [pmc_pkg::PMC_DATA_W-1:0]   reload_o,
   output logic [pmc_pkg::PMC_DATA_W-1:0]   power_o,
   output logic                             power_wr_o
);
   import pmc_pkg::*;

   typedef struct packed
   {
      logic [PMC_DATA_W-1:0]   reload;
      logic [PMC_DATA_W-1:0]   power;
      logic [PMC_DATA_W-1:0]   rdata;
   } pmc_regs_s;

   pmc_regs_s   q;
   pmc_regs_s   next_q;
   logic        wr_reload;
   logic        wr_power;

   function automatic logic hit(input logic [PMC_ADDR_W-1:0] a,
                                input logic [PMC_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign wr_reload = bus_i.wr && hit(bus_i.addr, PMC_OFS_RELOAD);
   assign wr_power  = bus_i.wr && hit(bus_i.addr, PMC_OFS_POWER);

   always_comb
   begin
      next_q = q;
      if (wr_reload)
      begin
         next_q.reload = bus_i.wdata;
      end
      if (wr_power)
      begin
         next_q.power = bus_i.wdata & PMC_WMASK_POWER;
      end
      else if (hw_clr_mode_i)
      begin
         next_q.power[PMC_BIT_PDOWN] = 1'b0;
         next_q.power[PMC_BIT_IDLE]  = 1'b0;
      end
      next_q.rdata = '0;
      if (bus_i.rd && hit(bus_i.addr, PMC_OFS_RELOAD))
      begin
         next_q.rdata = q.reload;
      end
      else if (bus_i.rd && hit(bus_i.addr, PMC_OFS_POWER))
      begin
         next_q.rdata = q.power;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!por_done_i)
      begin
         q.reload <= PMC_RST_RELOAD;
         q.power  <= PMC_RST_POWER;
         q.rdata  <= '0;
      end
      else if (!rst_b_i)
      begin
         q.reload <= PMC_RST_RELOAD;
         // warm reset keeps only the power-on flag
         q.power  <= PMC_RST_POWER & q.power;
         q.rdata  <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign reload_o   = q.reload;
   assign power_o    = q.power;
   assign rdata_o    = q.rdata;
   assign power_wr_o = wr_power;

endmodule : pmc_regs

// *** design/pmc_top.sv ***
/*
 pmc_top: power mode control for an 8-bit core.
 holds the wake reload byte and the power mode register, gates the cpu
 clock for idle and power-down and the peripheral clock for power-down, and hands serial-port
 controls onward. assumes the core raises sfr strobes on ref_clk_i,
 that por_done_i is low until a cold start completes, and that the
 interrupt controller reports a pending wake source on wake_irq_i.
*/
// Our own choice: strobed register access.
`timescale 1ns/1ps
module pmc_top
(
   // clock and reset
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        por_done_i,
   // register port
   input  wire logic                        sfr_wr_i,
   input  wire logic                        sfr_rd_i,
   input  wire logic [pmc_pkg::PMC_ADDR_W-1:0] sfr_addr_i,
   input  wire logic [pmc_pkg::PMC_DATA_W-1:0] sfr_wdata_i,
   output logic [pmc_pkg::PMC_DATA_W-1:0]   sfr_rdata_o,
   // wake source
   input  wire logic                        wake_irq_i,
   input  wire logic                        wake_pin_i,
   // clock and core control
   output logic                             cpu_clk_en_o,
   output logic                             periph_clk_en_o,
   output logic                             pc_hold_o,
   output logic                             wake_isr_go_o,
   output logic [1:0]                       power_mode_o,
   // towards wake timer and serial port 0
   output logic [pmc_pkg::PMC_DATA_W-1:0]   wakeup_reload_byte_o,
   output logic                             baud_double_o,
   output logic                             frame_error_access_select_o,
   output logic                             power_on_flag_o,
   output logic                             general_flag_1_o,
   output logic                             general_flag_0_o
);
   import pmc_pkg::*;

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed
   {
      pmc_mode_e               mode;
      logic [2:0]              settle;
      pmc_clk_s                clk;
      logic [PMC_DATA_W-1:0]   reload;
      logic [PMC_DATA_W-1:0]   pwr;
   } pmc_top_s;

   pmc_top_s                q;
   pmc_top_s                next_q;
   pmc_bus_s                bus;
   logic [PMC_DATA_W-1:0]   rdata;
   logic [PMC_DATA_W-1:0]   reload;
   logic [PMC_DATA_W-1:0]   power;
   logic                    power_wr;
   logic                    hw_clr;
   logic                    pin_level;
   logic                    wake;

   localparam logic [2:0] SETTLE_CYC = 3'(PMC_WAKE_SETTLE_CYC);

   assign bus.wr    = sfr_wr_i;
   assign bus.rd    = sfr_rd_i;
   assign bus.addr  = sfr_addr_i;
   assign bus.wdata = sfr_wdata_i;

   // ==========================================================
   // registers
   // ==========================================================
   pmc_regs u_regs
   (
      .ref_clk_i     (ref_clk_i),
      .rst_b_i       (rst_b_i),
      .por_done_i    (por_done_i),
      .bus_i         (bus),
      .rdata_o       (rdata),
      .hw_clr_mode_i (hw_clr),
      .reload_o      (reload),
      .power_o       (power),
      .power_wr_o    (power_wr)
   );

   // ==========================================================
   // external wake pin
   // ==========================================================
   pmc_sync u_wake_sync
   (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   (wake_pin_i),
      .level_o   (pin_level)
   );

   // interrupt on same clock; the synced pin wakes either low-power mode
   assign wake   = wake_irq_i || pin_level;
   // cleared as the wake sequence starts
   assign hw_clr = (q.mode == PMC_IDLE || q.mode == PMC_PDOWN) && wake;

   // ==========================================================
   // mode machine
   // ==========================================================
   always_comb
   begin
      next_q                   = q;
      next_q.reload            = reload;
      next_q.pwr               = power;
      next_q.clk.wake_isr_go   = 1'b0;
      case (q.mode)
         PMC_RUN:
         begin
            // request checked on the write itself; power-down wins
            if (power_wr && sfr_wdata_i[PMC_BIT_PDOWN])
            begin
               next_q.mode = PMC_PDOWN;
            end
            else if (power_wr && sfr_wdata_i[PMC_BIT_IDLE])
            begin
               next_q.mode = PMC_IDLE;
            end
         end
         PMC_IDLE:
         begin
            if (wake)
            begin
               next_q.mode   = PMC_WAKE;
               next_q.settle = SETTLE_CYC;
            end
         end
         PMC_PDOWN:
         begin
            // leaves straight to wake, never through idle
            if (wake)
            begin
               next_q.mode   = PMC_WAKE;
               next_q.settle = SETTLE_CYC;
            end
         end
         PMC_WAKE:
         begin
            if (q.settle <= 3'd1)
            begin
               next_q.mode            = PMC_RUN;
               next_q.settle          = 3'd0;
               next_q.clk.wake_isr_go = 1'b1;
            end
            else
            begin
               next_q.settle = q.settle - 3'd1;
            end
         end
         default:
         begin
            next_q.mode = PMC_RUN;
         end
      endcase

      // pc held in idle and power-down, released for the isr; the
      // return address is the instruction after the request
      next_q.clk.pc_hold       = (next_q.mode != PMC_RUN);
      next_q.clk.cpu_clk_en    = (next_q.mode == PMC_RUN);
      next_q.clk.periph_clk_en = (next_q.mode != PMC_PDOWN);
   end

   always_ff @(posedge ref_clk_i)
   begin
      // a cold start must also leave the core running
      if (!rst_b_i || !por_done_i)
      begin
         q.mode   <= PMC_RUN;
         q.settle <= 3'd0;
         q.clk    <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                       pc_hold: 1'b0, wake_isr_go: 1'b0};
         q.reload <= PMC_RST_RELOAD;
         q.pwr    <= PMC_RST_POWER;
      end
      else
      begin
         q <= next_q;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign sfr_rdata_o                 = rdata;
   assign cpu_clk_en_o                = q.clk.cpu_clk_en;
   assign periph_clk_en_o             = q.clk.periph_clk_en;
   assign pc_hold_o                   = q.clk.pc_hold;
   assign wake_isr_go_o               = q.clk.wake_isr_go;
   assign power_mode_o                = q.mode;
   assign wakeup_reload_byte_o        = q.reload;
   assign baud_double_o               = q.pwr[PMC_BIT_BAUD_DOUBLE];
   assign frame_error_access_select_o = q.pwr[PMC_BIT_FRM_SELECT];
   assign power_on_flag_o             = q.pwr[PMC_BIT_POWER_ON];
   assign general_flag_1_o            = q.pwr[PMC_BIT_GFLAG1];
   assign general_flag_0_o            = q.pwr[PMC_BIT_GFLAG0];

endmodule : pmc_top

// *** testbench/pmc_top_sva.sv ***
/*
 pmc_top_sva: port assertions for pmc_top.
 assumes the bench binds it to the top instance.
*/
`timescale 1ns/1ps
module pmc_top_sva
(
   // clock, resets, bus
   input  wire logic         ref_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         por_done_i,
   input  wire logic         sfr_wr_i,
   input  wire logic         sfr_rd_i,
   input  wire logic [7:0]   sfr_addr_i,
   input  wire logic [7:0]   sfr_wdata_i,
   input  wire logic [7:0]   sfr_rdata_o,
   // wake and clock control
   input  wire logic         wake_irq_i,
   input  wire logic         cpu_clk_en_o,
   input  wire logic         periph_clk_en_o,
   input  wire logic         pc_hold_o,
   input  wire logic         wake_isr_go_o,
   input  wire logic [1:0]   power_mode_o
);
   // ==========
   // assertions
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i || !por_done_i);
   wire logic pwr_wr = sfr_wr_i && sfr_addr_i == 8'h87;

   property p_rd_idle;
      !$past(sfr_rd_i) |-> sfr_rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read slot");
   property p_reload_rb;
      sfr_wr_i && sfr_addr_i == 8'h86 ##1 sfr_rd_i && sfr_addr_i == 8'h86
      |=> sfr_rdata_o == $past(sfr_wdata_i, 2);
   endproperty
   a_reload_rb: assert property (p_reload_rb)
      else $error("reload byte read back wrong");
   property p_pwr_rb;
      pwr_wr && sfr_wdata_i[1:0] == 2'b00 ##1 sfr_rd_i && sfr_addr_i == 8'h87
      |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & 8'hDF);
   endproperty
   a_pwr_rb: assert property (p_pwr_rb)
      else $error("power register read back wrong");
   property p_bit5;
      $past(sfr_rd_i) && $past(sfr_addr_i) == 8'h87 |-> !sfr_rdata_o[5];
   endproperty
   a_bit5: assert property (p_bit5)
      else $error("unused bit reads one");
   property p_pdown_enter;
      pwr_wr && sfr_wdata_i[1] && power_mode_o == 2'b00
      |=> power_mode_o == 2'b11 && !periph_clk_en_o;
   endproperty
   a_pdown_enter: assert property (p_pdown_enter)
      else $error("power-down not entered");
   property p_idle_enter;
      pwr_wr && sfr_wdata_i[1:0] == 2'b01 && power_mode_o == 2'b00
      |=> power_mode_o == 2'b01 && periph_clk_en_o;
   endproperty
   a_idle_enter: assert property (p_idle_enter)
      else $error("idle not entered");
   property p_wake;
      power_mode_o[0] && wake_irq_i && !pwr_wr
      |=> (power_mode_o == 2'b10) [*4]
      ##1 (power_mode_o == 2'b00 && wake_isr_go_o) ##1 !wake_isr_go_o;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake sequence wrong");
   property p_go_src;
      $rose(wake_isr_go_o) |-> $past(power_mode_o) == 2'b10;
   endproperty
   a_go_src: assert property (p_go_src)
      else $error("isr start without wake");
   property p_gate;
      cpu_clk_en_o == (power_mode_o == 2'b00) && pc_hold_o == !cpu_clk_en_o;
   endproperty
   a_gate: assert property (p_gate)
      else $error("cpu clock or pc hold wrong for mode");
   property p_periph;
      !periph_clk_en_o |-> power_mode_o == 2'b11;
   endproperty
   a_periph: assert property (p_periph)
      else $error("peripheral clock stopped outside power-down");
   property p_run_stay;
      power_mode_o == 2'b00 && !pwr_wr |=> power_mode_o == 2'b00;
   endproperty
   a_run_stay: assert property (p_run_stay)
      else $error("left run without a request");
endmodule : pmc_top_sva

// *** testbench/tb_power_mode_control.sv ***
/*
 tb_power_mode_control: self-checking bench for pmc_top.
 assumes pmc_pkg is compiled first; integer model tracks both registers.
*/
`timescale 1ns/1ps
module tb_power_mode_control;
   import pmc_pkg::*;
   // ==========
   // signals
   logic       ref_clk_i, rst_b_i, por_done_i, sfr_wr_i, sfr_rd_i;
   logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, wakeup_reload_byte_o;
   logic       wake_irq_i, wake_pin_i, cpu_clk_en_o, periph_clk_en_o;
   logic       pc_hold_o, wake_isr_go_o, baud_double_o, power_on_flag_o;
   logic       frame_error_access_select_o, general_flag_1_o;
   logic       general_flag_0_o;
   logic [1:0] power_mode_o;
   logic [31:0] seed = 32'h0000_004A;
   logic [31:0] d, a;
   logic [7:0] mv [3] = '{8'h8D, 8'h02, 8'h03};
   int         n_fail, tests_run, reload_m, pwr_m, n, cyc;

   pmc_top dut (.ref_clk_i, .rst_b_i, .por_done_i, .sfr_wr_i, .sfr_rd_i,
      .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .wake_irq_i, .wake_pin_i,
      .cpu_clk_en_o, .periph_clk_en_o, .pc_hold_o, .wake_isr_go_o,
      .power_mode_o, .wakeup_reload_byte_o, .baud_double_o,
      .frame_error_access_select_o, .power_on_flag_o, .general_flag_1_o,
      .general_flag_0_o);

   initial
   begin
      ref_clk_i = 0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // ==========
   // tasks
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task op(input logic w, input logic r, input logic [7:0] ad, dd);
      sfr_wr_i    <= w;
      sfr_rd_i    <= r;
      sfr_addr_i  <= ad;
      sfr_wdata_i <= dd;
      @(posedge ref_clk_i);
   endtask : op
   // write leaves the strobe up so a read may follow with no gap
   task wr(input logic [7:0] ad, dd);
      op(1'b1, 1'b0, ad, dd);
      if (ad == 8'h86) reload_m = dd;
      if (ad == 8'h87) pwr_m = dd & 8'hDF;
   endtask : wr
   task rd(input logic [7:0] ad);
      op(1'b0, 1'b1, ad, 8'h00);
      sfr_rd_i <= 0;
      @(posedge ref_clk_i);
      chk(sfr_rdata_o, ad == 8'h86 ? 8'(reload_m) :
          ad == 8'h87 ? 8'(pwr_m) : 8'h00);
   endtask : rd
   task idle(input int c);
      sfr_wr_i <= 0;
      sfr_rd_i <= 0;
      repeat (c) @(posedge ref_clk_i);
   endtask : idle
   task rst(input logic cold);
      if (cold) por_done_i <= 0;
      else rst_b_i <= 0;
      idle(2);
      por_done_i <= 1;
      rst_b_i    <= 1;
      reload_m = 0;
      pwr_m = cold ? 8'h10 : pwr_m & 8'h10;
      idle(3);
   endtask : rst
   task mir;
      chk(wakeup_reload_byte_o, 8'(reload_m));
      chk({baud_double_o, frame_error_access_select_o, 1'b0,
           power_on_flag_o, general_flag_1_o, general_flag_0_o, 2'b00},
          8'(pwr_m) & 8'hDC);
   endtask : mir
   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         summarize();
      end
   end

   // ==========
   // main sequence
   initial
   begin
      {rst_b_i, por_done_i, sfr_wr_i, sfr_rd_i, wake_irq_i, wake_pin_i} = 0;
      sfr_addr_i = 0;
      sfr_wdata_i = 0;
      reload_m = 0;
      pwr_m = 8'h10;
      repeat (16) @(posedge ref_clk_i);
      rst_b_i    <= 1;
      por_done_i <= 1;
      @(posedge ref_clk_i);
      rd(8'h86);
      rd(8'h87);
      for (int i = 0; i < 8; i++)
      begin
         d = xs();
         if (d[7:0] == 8'hFF) d = 0;
         wr(8'h86, d[7:0]);
         rd(8'h86);
         a = xs();
         if (a[7:1] == 7'h43) a = 32'h0000_0020;
         rd(a[7:0]);
         wr(8'h87, d[7:0] & 8'hFC);
         rd(8'h87);
         idle(3);
         mir();
      end
      wr(8'h87, 8'h10);
      rst(1'b0);
      rd(8'h87);
      wr(8'h87, 8'hCC);
      rst(1'b0);
      rd(8'h87);
      rst(1'b1);
      mir();
      foreach (mv[i])
      begin
         wr(8'h87, mv[i]);
         idle(2);
         chk(power_mode_o, mv[i][1] ? 2'b11 : 2'b01);
         chk(cpu_clk_en_o, 1'b0);
         chk(periph_clk_en_o, !mv[i][1]);
         chk(pc_hold_o, 1'b1);
         if (i == 1) wake_pin_i <= 1;
         else wake_irq_i <= 1;
         n = 0;
         while (wake_isr_go_o !== 1'b1 && n < 20)
         begin
            @(posedge ref_clk_i);
            n++;
         end
         wake_irq_i <= 0;
         wake_pin_i <= 0;
         chk(n < 20, 1'b1);
         chk(cpu_clk_en_o, 1'b1);
         chk(pc_hold_o, 1'b0);
         pwr_m = pwr_m & 8'hFC;
         idle(6);
         chk(power_mode_o, 2'b00);
         rd(8'h87);
      end
      wake_irq_i <= 1;
      repeat (6)
      begin
         @(posedge ref_clk_i);
         chk(power_mode_o, 2'b00);
      end
      wake_irq_i <= 0;
      summarize();
   end
endmodule : tb_power_mode_control

bind pmc_top pmc_top_sva u_sva (.ref_clk_i, .rst_b_i, .por_done_i,
   .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o,
   .wake_irq_i, .cpu_clk_en_o, .periph_clk_en_o, .pc_hold_o,
   .wake_isr_go_o, .power_mode_o);
